// ===== core/preact_pkg.sv
package preact_pkg;

    localparam int W_W         = 24;
    localparam int T_W         = 16;
    localparam int CLK_MHZ     = 100;
    localparam int TICK_US     = 100000;
    localparam int TICK_CYC    = TICK_US * CLK_MHZ;
    localparam int TICKS_PER_S = 10;

    localparam logic [T_W-1:0] START_WAIT_RST  = 16'h0014;
    localparam logic [T_W-1:0] UPDATE_TIME_RST = 16'h0014;
    localparam logic [3:0]     CAPTURE_AVG_RST = 4'h3;
    localparam logic           AUTO_EN_RST     = 1'b0;
    localparam logic [7:0]     STABLE_TOL_RST  = 8'h0A;
    localparam logic [7:0]     FRC_TOL_RST     = 8'h14;
    localparam logic [7:0]     FAST_ADJ_RST    = 8'h0A;
    localparam logic [7:0]     P_GAIN_RST      = 8'h0D;
    localparam logic [7:0]     I_GAIN_RST      = 8'hA6;
    localparam logic [3:0]     STEADY_CNT_RST  = 4'h3;
    localparam logic [W_W-1:0] CAPTURE_TOL_RST = 24'h00000A;

    typedef enum logic [2:0] {
        PH_IDLE   = 3'b000,
        PH_FILL   = 3'b001,
        PH_SETTLE = 3'b011,
        PH_LEARN  = 3'b010
    } phase_t;

endpackage : preact_pkg

// ===== core/tick_gen.sv
module tick_gen #(
    parameter int DIV = 10000000
) (
    input  wire logic clk_in,     // System clock
    input  wire logic rstn_in,    // Sync reset, low
    input  wire logic restart_in, // Realign timebase
    output logic      tick_out    // One-cycle tick
);
    logic [31:0] cnt_reg;
    logic        tick_reg;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in || restart_in)
        begin
            cnt_reg  <= 32'h00000000;
            tick_reg <= 1'b0;
        end
        else if (cnt_reg == 32'(DIV - 1))
        begin
            cnt_reg  <= 32'h00000000;
            tick_reg <= 1'b1;
        end
        else
        begin
            cnt_reg  <= cnt_reg + 32'h00000001;
            tick_reg <= 1'b0;
        end
    end

    assign tick_out = tick_reg;
endmodule : tick_gen

// ===== core/fill_preact_learning_unit.sv
// Overview of operation
// - Setpoint equals target minus applied preact
// - Ignore flow rate during start wait
// - Wait update time before sampling weight
// - Average error and rate over cycles
// - Select learned or host preact
// - Learned preact from PI plus rate
// - Flow stable within stable tolerance
// - Ignore rate swings below frc tolerance
// - Zero frc tolerance disables rate term
// - Overshoot trims fast target by fast-adjust
// - Report time to fast relay change
// - Report time to slow relay change
// - Report time to flow stable
// - Report relay-to-steady time
// - Flag flow never stable before relay
// - Flag weight never steady before update
// - Settle failure freezes learned preact
// - Fast target change clears learned preact, except in a PH_LEARN cycle that updates it
// - Learned preact acts on slow relay only
module fill_preact_learning_unit #(
    parameter int TICK_DIV = preact_pkg::TICK_CYC
) (
    input  wire logic                         clk_in,           // 100 MHz clock
    input  wire logic                         rstn_in,          // Sync reset, low
    input  wire logic                         cycle_start_in,   // Fill cycle start pulse
    input  wire logic                         two_speed_in,     // Fast/slow feed in use
    input  wire logic [preact_pkg::W_W-1:0]   net_weight_in,    // Absolute net weight
    input  wire logic [preact_pkg::W_W-1:0]   flow_rate_in,     // Rate of change
    input  wire logic [preact_pkg::W_W-1:0]   target_in,        // Slow relay target
    input  wire logic [preact_pkg::W_W-1:0]   fast_target_in,   // Fast relay target
    input  wire logic [preact_pkg::W_W-1:0]   ext_preact_in,    // Host preact
    input  wire logic                         auto_en_in,       // Use learned preact
    input  wire logic [preact_pkg::T_W-1:0]   start_wait_in,    // Ticks
    input  wire logic [preact_pkg::T_W-1:0]   update_time_in,   // Ticks
    input  wire logic [3:0]                   capture_avg_in,   // Cycles averaged
    input  wire logic [7:0]                   stable_tol_in,    // Percent x10
    input  wire logic [7:0]                   frc_tol_in,       // Percent x10
    input  wire logic [7:0]                   fast_adj_in,      // Percent x10
    input  wire logic [7:0]                   p_gain_in,        // Gain /256
    input  wire logic [7:0]                   i_gain_in,        // Gain /256
    input  wire logic [3:0]                   steady_cnt_in,    // Steady periods
    input  wire logic [preact_pkg::W_W-1:0]   capture_tol_in,   // Weight band
    input  wire logic                         preact_clr_in,    // Clear learned preact, except in a PH_LEARN cycle that updates it
    output logic [preact_pkg::W_W-1:0]        setpoint_out,     // Slow trip weight
    output logic [preact_pkg::W_W-1:0]        fast_trip_out,    // Fast trip weight
    output logic                              fast_relay_out,   // Fast feed on
    output logic                              slow_relay_out,   // Slow feed on
    output logic [preact_pkg::W_W-1:0]        preact_out,       // Learned preact
    output logic [preact_pkg::T_W-1:0]        fast_time_out,    // Ticks to fast trip
    output logic [preact_pkg::T_W-1:0]        slow_time_out,    // Ticks to slow trip
    output logic [preact_pkg::T_W-1:0]        stable_time_out,  // Ticks to stable flow
    output logic [preact_pkg::T_W-1:0]        steady_time_out,  // Ticks trip to steady
    output logic                              not_stable_out,   // Flow never stable
    output logic                              settle_fail_flag_out // Weight not steady
);
    localparam int W = preact_pkg::W_W;
    localparam int T = preact_pkg::T_W;

    typedef struct packed {
        preact_pkg::phase_t phase;
        logic [W-1:0] preact;
        logic [W-1:0] fast_tgt;
        logic [W-1:0] fast_seen;
        logic [W-1:0] rmin;
        logic [W-1:0] rmax;
        logic [W-1:0] rate_hold;
        logic [W-1:0] last_w;
        logic [W+3:0] err_acc;
        logic [W+3:0] rate_acc;
        logic [3:0]   ncyc;
        logic [T-1:0] tcnt;
        logic [T-1:0] trip_cnt;
        logic [3:0]   steady_run;
        logic         stable;
        logic         steady;
        logic         fast_on;
        logic         slow_on;
        logic [T-1:0] fast_t;
        logic [T-1:0] slow_t;
        logic [T-1:0] stable_t;
        logic [T-1:0] steady_t;
        logic         not_stable;
        logic         not_steady;
    } state_t;

    state_t s_reg, s_next;
    logic   tick;
    logic [W-1:0] w_s2_reg, r_s2_reg;
    logic [W-1:0] sync_in    [2];
    logic [W-1:0] sync_a_reg [2];
    logic [W-1:0] sync_b_reg [2];

    tick_gen #(.DIV(TICK_DIV)) u_tick (
        .clk_in     (clk_in),
        .rstn_in    (rstn_in),
        .restart_in (cycle_start_in),
        .tick_out   (tick)
    );

    assign sync_in[0] = net_weight_in;
    assign sync_in[1] = flow_rate_in;

    // Scale words come from the converter side: two stages before any use
    for (genvar g = 0; g < 2; g++)
    begin : g_sync
        always_ff @(posedge clk_in)
        begin
            sync_a_reg[g] <= sync_in[g];
            sync_b_reg[g] <= sync_a_reg[g];
        end
    end

    assign w_s2_reg = sync_b_reg[0];
    assign r_s2_reg = sync_b_reg[1];

    function automatic logic [W-1:0] scale_pct(input logic [W-1:0] v, input logic [7:0] p);
        logic [W+9:0] prod;
        prod = (W+10)'(v) * (W+10)'(p);
        scale_pct = W'(prod / (W+10)'(1000));
    endfunction : scale_pct

    // Signed: errors and the preact may fall either side of zero
    function automatic logic [W-1:0] scale_gain(input logic [W-1:0] v, input logic [7:0] g);
        logic signed [W+8:0] prod;
        prod = $signed({{9{v[W-1]}}, v}) * $signed({1'b0, g});
        scale_gain = W'(prod >>> 8);
    endfunction : scale_gain

    // Sign extension into the accumulator width
    function automatic logic [W+3:0] widen_s(input logic [W-1:0] v);
        widen_s = {{4{v[W-1]}}, v};
    endfunction : widen_s

    // Clamp the learned preact instead of letting a runaway sum flip sign
    function automatic logic [W-1:0] sat_sum(input logic [W-1:0] a, input logic [W-1:0] b,
                                             input logic [W-1:0] c);
        logic signed [W+1:0] sum;
        sum = $signed({{2{a[W-1]}}, a}) + $signed({{2{b[W-1]}}, b}) + $signed({{2{c[W-1]}}, c});
        if (sum > $signed({3'b000, {(W-1){1'b1}}}))
            sat_sum = {1'b0, {(W-1){1'b1}}};
        else if (sum < $signed({3'b111, {(W-1){1'b0}}}))
            sat_sum = {1'b1, {(W-1){1'b0}}};
        else
            sat_sum = W'(sum);
    endfunction : sat_sum

    logic [W-1:0] applied_preact, slow_sp, span, err, avg_err, avg_rate, p_term, i_term;
    logic [W-1:0] rate_term;
    logic         in_band;

    always_comb
    begin
        applied_preact = auto_en_in ? s_reg.preact : ext_preact_in;
        slow_sp  = target_in - applied_preact;
        span     = s_reg.rmax - s_reg.rmin;
        in_band  = (w_s2_reg >= s_reg.last_w ? w_s2_reg - s_reg.last_w
                                               : s_reg.last_w - w_s2_reg) <= capture_tol_in;
        err      = w_s2_reg - target_in;
        avg_err  = W'($signed(s_reg.err_acc + widen_s(err))
                      / $signed((W+4)'(s_reg.ncyc + 4'h1)));
        avg_rate = W'((s_reg.rate_acc + (W+4)'(s_reg.rate_hold))
                      / (W+4)'(s_reg.ncyc + 4'h1));
        p_term   = scale_gain(err, p_gain_in);
        i_term   = scale_gain(avg_err, i_gain_in);
        rate_term = (frc_tol_in == 8'h00) ? '0 : scale_gain(avg_rate, i_gain_in);
    end

    always_comb
    begin
        s_next = s_reg;
        if (fast_target_in != s_reg.fast_seen)
        begin
            s_next.fast_seen = fast_target_in;
            s_next.fast_tgt  = fast_target_in;
            s_next.preact    = '0;
        end
        if (preact_clr_in)
        begin
            s_next.preact   = '0;
            s_next.err_acc  = '0;
            s_next.rate_acc = '0;
            s_next.ncyc     = 4'h0;
        end
        if (tick)
        begin
            s_next.tcnt = s_reg.tcnt + T'(1);
        end
        unique case (s_reg.phase)
            preact_pkg::PH_IDLE:
            begin
            end
            preact_pkg::PH_FILL:
            begin
                if (tick && s_reg.tcnt >= start_wait_in)
                begin
                    if (r_s2_reg < s_reg.rmin)
                    begin
                        s_next.rmin = r_s2_reg;
                    end
                    if (r_s2_reg > s_reg.rmax)
                    begin
                        s_next.rmax = r_s2_reg;
                    end
                    if (!s_reg.stable && span <= scale_pct(s_reg.rmax, stable_tol_in)
                        && s_reg.rmax != '0)
                    begin
                        s_next.stable   = 1'b1;
                        s_next.stable_t = s_reg.tcnt;
                        s_next.rate_hold = r_s2_reg;
                    end
                    else if (s_reg.stable && span < scale_pct(s_reg.rmax, frc_tol_in))
                    begin
                        s_next.rate_hold = s_reg.rate_hold;
                    end
                    else if (s_reg.stable)
                    begin
                        s_next.rate_hold = r_s2_reg;
                    end
                end
                if (s_reg.fast_on && two_speed_in && w_s2_reg >= s_reg.fast_tgt)
                begin
                    s_next.fast_on = 1'b0;
                    s_next.fast_t  = s_reg.tcnt;
                end
                if (w_s2_reg >= slow_sp && (!two_speed_in || !s_reg.fast_on))
                begin
                    s_next.slow_on    = 1'b0;
                    s_next.fast_on    = 1'b0;
                    s_next.slow_t     = s_reg.tcnt;
                    s_next.not_stable = !s_reg.stable;
                    s_next.trip_cnt   = '0;
                    s_next.steady_run = 4'h0;
                    s_next.last_w     = w_s2_reg;
                    s_next.phase      = preact_pkg::PH_SETTLE;
                end
            end
            preact_pkg::PH_SETTLE:
            begin
                if (tick)
                begin
                    s_next.trip_cnt = s_reg.trip_cnt + T'(1);
                    s_next.last_w   = w_s2_reg;
                    s_next.steady_run = in_band ? s_reg.steady_run + 4'h1 : 4'h0;
                    if (!s_reg.steady && in_band && s_reg.steady_run + 4'h1 >= steady_cnt_in)
                    begin
                        s_next.steady   = 1'b1;
                        s_next.steady_t = s_reg.trip_cnt + T'(1);
                    end
                    if (s_reg.trip_cnt + T'(1) >= update_time_in)
                    begin
                        s_next.not_steady = !s_next.steady;
                        s_next.phase      = preact_pkg::PH_LEARN;
                    end
                end
            end
            preact_pkg::PH_LEARN:
            begin
                if (!s_reg.not_steady)
                begin
                    // Learning sees only the slow relay result
                    s_next.preact = sat_sum(i_term, p_term, rate_term);
                    if (s_reg.ncyc + 4'h1 >= capture_avg_in)
                    begin
                        s_next.err_acc  = widen_s(avg_err);
                        s_next.rate_acc = (W+4)'(avg_rate);
                    end
                    else
                    begin
                        s_next.err_acc  = s_reg.err_acc + widen_s(err);
                        s_next.rate_acc = s_reg.rate_acc + (W+4)'(s_reg.rate_hold);
                        s_next.ncyc     = s_reg.ncyc + 4'h1;
                    end
                    if (two_speed_in && w_s2_reg > target_in && fast_adj_in != 8'h00)
                    begin
                        s_next.fast_tgt = s_reg.fast_tgt
                                        - scale_pct(s_reg.fast_tgt, fast_adj_in);
                        s_next.preact = ($signed(s_reg.preact)
                                         < $signed(scale_pct(target_in, fast_adj_in)))
                                      ? '0 : s_reg.preact - scale_pct(s_reg.preact, fast_adj_in);
                    end
                end
                s_next.phase = preact_pkg::PH_IDLE;
            end
            default:
            begin
                s_next.phase = preact_pkg::PH_IDLE;
            end
        endcase
        if (cycle_start_in)
        begin
            s_next.phase      = preact_pkg::PH_FILL;
            s_next.tcnt       = '0;
            s_next.rmin       = '1;
            s_next.rmax       = '0;
            s_next.stable     = 1'b0;
            s_next.steady     = 1'b0;
            s_next.fast_on    = two_speed_in;
            s_next.slow_on    = 1'b1;
            s_next.stable_t   = '0;
            s_next.steady_t   = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            s_reg       <= '0;
            s_reg.phase <= preact_pkg::PH_IDLE;
            s_reg.rmin  <= '1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    logic [W-1:0] sp_reg;
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            sp_reg <= '0;
        end
        else
        begin
            sp_reg <= slow_sp;
        end
    end

    assign setpoint_out         = sp_reg;
    assign fast_trip_out        = s_reg.fast_tgt;
    assign fast_relay_out       = s_reg.fast_on;
    assign slow_relay_out       = s_reg.slow_on;
    assign preact_out           = s_reg.preact;
    assign fast_time_out        = s_reg.fast_t;
    assign slow_time_out        = s_reg.slow_t;
    assign stable_time_out      = s_reg.stable_t;
    assign steady_time_out      = s_reg.steady_t;
    assign not_stable_out       = s_reg.not_stable;
    assign settle_fail_flag_out = s_reg.not_steady;
endmodule : fill_preact_learning_unit

// ===== bench/fill_preact_checker.sv
module fill_preact_checker #(
    parameter int TICK_DIV = 10,
    parameter int W        = preact_pkg::W_W,
    parameter int T        = preact_pkg::T_W
) (
    input wire logic         clk_in,              // Clock
    input wire logic         rstn_in,             // Reset
    input wire logic         cycle_start_in,      // Start
    input wire logic         auto_en_in,          // Select
    input wire logic         preact_clr_in,       // Clear
    input wire logic [W-1:0] target_in,           // Target
    input wire logic [W-1:0] fast_target_in,      // Fast target
    input wire logic [W-1:0] ext_preact_in,       // Host preact
    input wire logic [W-1:0] net_weight_in,       // Weight
    input wire logic [W-1:0] setpoint_out,        // Slow trip
    input wire logic [W-1:0] fast_trip_out,       // Fast trip
    input wire logic         fast_relay_out,      // Fast feed
    input wire logic         slow_relay_out,      // Slow feed
    input wire logic [W-1:0] preact_out,          // Learned
    input wire logic [T-1:0] fast_time_out,       // Fast ticks
    input wire logic [T-1:0] slow_time_out,       // Slow ticks
    input wire logic         settle_fail_flag_out // Settle fail
);
    int cyc_reg;
    int quiet_reg;

    // Cycles since start, and since the last preact clear
    always_ff @(posedge clk_in)
    begin
        cyc_reg   <= cycle_start_in ? 0 : cyc_reg + 1;
        quiet_reg <= (preact_clr_in || $changed(fast_target_in)) ? 0 : quiet_reg + 1;
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_slow_reached;
        slow_relay_out && net_weight_in >= setpoint_out;
    endsequence
    sequence s_fast_reached;
        fast_relay_out && net_weight_in >= fast_trip_out;
    endsequence
    sequence s_host_held;
        !auto_en_in && !$past(auto_en_in) && $stable(target_in) && $stable(ext_preact_in);
    endsequence

    chk_relay_start: assert property (cycle_start_in |=> slow_relay_out)
        else $error("slow feed not opened");
    chk_host_setpoint: assert property (
        s_host_held |=> setpoint_out == $past(target_in) - $past(ext_preact_in))
        else $error("setpoint wrong");
    chk_slow_trip: assert property (s_slow_reached |-> ##[1:5] !slow_relay_out)
        else $error("slow feed not closed");
    chk_fast_trip: assert property (s_fast_reached |-> ##[1:5] !fast_relay_out)
        else $error("fast feed not closed");
    chk_slow_time: assert property ($fell(slow_relay_out) |->
        slow_time_out * TICK_DIV <= cyc_reg + 2 * TICK_DIV
        && cyc_reg <= (slow_time_out + 2) * TICK_DIV)
        else $error("slow time wrong");
    chk_fast_time: assert property ($fell(fast_relay_out) |->
        fast_time_out * TICK_DIV <= cyc_reg + 2 * TICK_DIV
        && cyc_reg <= (fast_time_out + 2) * TICK_DIV)
        else $error("fast time wrong");
    chk_preact_clear: assert property (
        preact_clr_in || $changed(fast_target_in) |-> ##[1:5] preact_out == '0)
        else $error("preact not cleared");
    chk_settle_hold: assert property (
        settle_fail_flag_out && quiet_reg >= 6 |=> !settle_fail_flag_out || $stable(preact_out))
        else $error("preact moved on settle fail");
endmodule : fill_preact_checker

bind fill_preact_learning_unit fill_preact_checker #(.TICK_DIV(TICK_DIV)) chk_i (
    .clk_in(clk_in), .rstn_in(rstn_in), .cycle_start_in(cycle_start_in),
    .auto_en_in(auto_en_in), .preact_clr_in(preact_clr_in), .target_in(target_in),
    .fast_target_in(fast_target_in), .ext_preact_in(ext_preact_in),
    .net_weight_in(net_weight_in), .setpoint_out(setpoint_out),
    .fast_trip_out(fast_trip_out), .fast_relay_out(fast_relay_out),
    .slow_relay_out(slow_relay_out), .preact_out(preact_out),
    .fast_time_out(fast_time_out), .slow_time_out(slow_time_out),
    .settle_fail_flag_out(settle_fail_flag_out)
);

// ===== bench/scale_model.sv
module scale_model (
    input  wire logic        clk_in,                     // Clock
    input  wire logic        tare_in,                    // Zero the load
    input  wire logic        feed_in,                    // A feed is open
    input  wire logic        wobble_in,                  // Load never settles
    input  wire logic [23:0] rate_in,                    // Gain per cycle
    output logic      [23:0] weight_out = 24'h000000,    // Net weight
    output logic      [23:0] flow_out = 24'h000000       // Measured rate
);
    timeunit 1ns;
    timeprecision 1ps;
    int tail;

    // In-flight material keeps landing for three cycles after the feed shuts
    always @(posedge clk_in)
    begin
        tail <= feed_in ? 3 : (tail > 0 ? tail - 1 : 0);
        flow_out <= feed_in ? rate_in : 24'h000000;
        if (tare_in)
            weight_out <= 24'h000000;
        else if (feed_in || tail > 0)
            weight_out <= weight_out + rate_in;
        else if (wobble_in)
            weight_out <= weight_out + 24'h000100;
    end
endmodule : scale_model

// ===== bench/fill_preact_learning_unit_tb.sv
module fill_preact_learning_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TD = 10;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        start = 1'b0;
    logic        two_spd = 1'b0;
    logic        auto_en = 1'b0;
    logic        clr = 1'b0;
    logic        tare = 1'b0;
    logic        wobble = 1'b0;
    logic [23:0] target = 24'h002000;
    logic [23:0] fast_tgt = 24'h000400;
    logic [23:0] ext = 24'h000000;
    logic [23:0] rate = 24'h000010;
    logic [23:0] weight, flow, setpoint, preact;
    logic [15:0] swait = 16'h0003;
    logic [15:0] upd = 16'h000C;
    logic [15:0] fast_t, slow_t, stab_t, steady_t;
    logic [7:0]  frc = preact_pkg::FRC_TOL_RST;
    logic [7:0]  pgain = preact_pkg::P_GAIN_RST;
    logic [7:0]  stol = preact_pkg::STABLE_TOL_RST;
    logic        fast_rly, slow_rly, unstable, sfail;
    int          errors = 0;
    int          n_checks = 0;
    int          seed = 12396;
    int          cycles = 0;

    always #5 clk_in = ~clk_in;

    fill_preact_learning_unit #(.TICK_DIV(TD)) fill_preact_learning_unit_i (
        .clk_in(clk_in), .rstn_in(rstn_in), .cycle_start_in(start), .two_speed_in(two_spd),
        .net_weight_in(weight), .flow_rate_in(flow), .target_in(target),
        .fast_target_in(fast_tgt), .ext_preact_in(ext), .auto_en_in(auto_en),
        .start_wait_in(swait), .update_time_in(upd), .stable_tol_in(stol), .frc_tol_in(frc),
        .capture_avg_in(preact_pkg::CAPTURE_AVG_RST), .fast_adj_in(preact_pkg::FAST_ADJ_RST),
        .p_gain_in(pgain), .i_gain_in(preact_pkg::I_GAIN_RST),
        .steady_cnt_in(preact_pkg::STEADY_CNT_RST), .capture_tol_in(preact_pkg::CAPTURE_TOL_RST),
        .preact_clr_in(clr), .setpoint_out(setpoint), .fast_trip_out(),
        .fast_relay_out(fast_rly), .slow_relay_out(slow_rly), .preact_out(preact),
        .fast_time_out(fast_t), .slow_time_out(slow_t), .stable_time_out(stab_t),
        .steady_time_out(steady_t), .not_stable_out(unstable), .settle_fail_flag_out(sfail)
    );

    scale_model scale_model_i (
        .clk_in(clk_in), .tare_in(tare), .feed_in(fast_rly | slow_rly), .wobble_in(wobble),
        .rate_in(rate), .weight_out(weight), .flow_out(flow)
    );

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic step();
        @(posedge clk_in);
        #1;
    endtask : step

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [23:0] exp_setpoint(input logic [23:0] tgt, input logic [23:0] pre);
        return tgt - pre;
    endfunction : exp_setpoint

    task automatic run_fill(input int n);
        int          k;
        int          exp;
        logic [23:0] pre;
        target = 24'h002000 + 24'($random(seed) & 32'h1FFF);
        rate = 24'h000010 + 24'($random(seed) & 32'h1F);
        ext = 24'($random(seed) & 32'hFF);
        pgain = 8'($random(seed));
        stol = 8'h0A + 8'($random(seed) & 32'h0F);
        frc = n[2] ? 8'h00 : preact_pkg::FRC_TOL_RST;
        auto_en = n[0];
        two_spd = n[1];
        wobble = (n == 5);
        tare = 1'b1;
        step();
        tare = 1'b0;
        repeat (4) step();
        if (auto_en)
            check("setpoint", setpoint, exp_setpoint(target, preact));
        else
            check("setpoint", setpoint, exp_setpoint(target, ext));
        start = 1'b1;
        step();
        start = 1'b0;
        step();
        check("relay_on", slow_rly, 24'h1);
        k = 2;
        while (slow_rly !== 1'b0 && k < 3000)
        begin
            step();
            k++;
        end
        check("fill_done", 24'(k < 3000), 24'h1);
        exp = k / TD;
        check("slow_time", 24'(slow_t + 1 >= exp && slow_t <= exp + 1), 24'h1);
        check("stable_time", 24'(stab_t >= swait && stab_t <= slow_t), 24'h1);
        if (two_spd)
            check("fast_time", 24'(fast_t > 0 && fast_t <= slow_t), 24'h1);
        pre = preact;
        repeat ((upd + 2) * TD) step();
        check("settle_fail", sfail, 24'(wobble));
        if (wobble)
            check("held_preact", preact, pre);
        else
            check("steady_time", 24'(steady_t + 3 <= upd), 24'h1);
        check("unstable", unstable, 24'h0);
        $display("test %0d done", n);
    endtask : run_fill

    task automatic clear_test();
        fast_tgt = fast_tgt + 24'h000010;
        repeat (6) step();
        check("fast_change_clear", preact, 24'h000000);
        upd = 16'h000D;
        clr = 1'b1;
        step();
        clr = 1'b0;
        repeat (6) step();
        check("host_clear", preact, 24'h000000);
        $display("test clear done");
    endtask : clear_test

    initial
    begin
        repeat (20) step();
        rstn_in = 1'b1;
        for (int n = 0; n < 8; n++)
        begin
            run_fill(n);
            if (n == 3)
                clear_test();
        end
        report_and_stop();
    end
endmodule : fill_preact_learning_unit_tb
